//--- hdl/dfs_pkg.sv
// Package with register map, fields and timing constants of the diagnostics block
package dfs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_DIAG    = 8'h00;
  localparam logic [7:0] OFS_CLEAR   = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_CTRL    = 8'h18;
  localparam logic [7:0] OFS_LOG     = 8'h1C;
  localparam logic [7:0] OFS_TIME    = 8'h20;
  // Diagnostic status bit positions
  localparam int DG_TIMECODE  = 0;
  localparam int DG_HW        = 1;
  localparam int DG_CONFIG    = 2;
  localparam int DG_SAMPLING  = 3;
  localparam int DG_TIME      = 4;
  localparam int DG_FACTORY   = 5;
  localparam int DG_CALIB     = 6;
  localparam int DG_RESET     = 7;
  localparam int NUM_DIAG     = 8;
  localparam logic [7:0] MASK_AUTO     = 8'h01;
  localparam logic [7:0] MASK_RECOVER  = 8'h86;
  localparam logic [7:0] MASK_CRITICAL = 8'h78;
  // Interrupt status bits
  localparam int IRQ_NEW_FAULT = 0;
  localparam int IRQ_CRITICAL  = 1;
  localparam int IRQ_BATT_LOW  = 2;
  localparam int IRQ_LOG_DROP  = 3;
  localparam int NUM_IRQ       = 4;
  // Control register bits
  localparam int CTRL_ALARM_INV = 0;
  localparam int CTRL_CFG_CHG   = 1;
  // Event log codes (upper byte of a log entry)
  localparam logic [7:0] EV_DIAG_SET   = 8'h01;
  localparam logic [7:0] EV_DIAG_CLR   = 8'h02;
  localparam logic [7:0] EV_CFG_CHANGE = 8'h03;
  localparam logic [7:0] EV_RESET      = 8'h04;
  // Log memory depth
  localparam int LOG_AW    = 4;
  localparam int LOG_DEPTH = 16;
  // Restart pulse length
  localparam int    CLK_MHZ       = 250;
  localparam int    RESTART_NS    = 100;
  localparam int    RESTART_CYC   = (RESTART_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] RESTART_CYC8 = 8'(RESTART_CYC);
endpackage

//--- hdl/dfs_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
module dfs_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dfs_sync_st_t;

  dfs_sync_st_t st_ff;
  dfs_sync_st_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++) begin
      // A change counts once stage two and three agree
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.q;
endmodule

//--- hdl/dfs_log_mem.sv
// Event log memory with registered read data
module dfs_log_mem (
  input  wire logic                        pclk,
  input  wire logic                        we,
  input  wire logic [dfs_pkg::LOG_AW-1:0]  waddr,
  input  wire logic [31:0]                 wdata,
  input  wire logic [dfs_pkg::LOG_AW-1:0]  raddr,
  output logic      [31:0]                 rdata
);
  logic [31:0] mem_ff [dfs_pkg::LOG_DEPTH];
  logic [31:0] rdata_ff;

  always_ff @(posedge pclk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
    rdata_ff <= mem_ff[raddr];
  end

  assign rdata = rdata_ff;
endmodule

//--- hdl/dfs_diag_top.sv
// Diagnostics, fault classification, indicators and event log with an APB slave
module dfs_diag_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        batt_low_pin,
  input  wire logic        main_supply_pin,
  input  wire logic        backup_supply_pin,
  input  wire logic [7:0]  fault_pin,
  input  wire logic [3:0]  relay_req,
  input  wire logic [7:0]  diag_retained,
  output logic             backup_battery_low_indicator,
  output logic             main_power_indicator,
  output logic             backup_power_indicator,
  output logic             device_fault_flag,
  output logic             critical_error,
  output logic             device_restart,
  output logic             config_repair,
  output logic [3:0]       relay_out,
  output logic             alarm_relay_nc_closed,
  output logic [7:0]       diag_store,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]  diag;
    logic [7:0]  diag_prev;
    logic        loaded;
    logic [31:0] tstamp;
    logic [3:0]  wptr;
    logic [4:0]  count;
    logic [3:0]  irq_st;
    logic [3:0]  irq_en;
    logic [1:0]  ctrl;
    logic [3:0]  rptr;
    logic [7:0]  restart_cnt;
    logic        led_bat;
    logic        led_main;
    logic        led_bkp;
    logic        fault_flag;
    logic        crit;
    logic        restart;
    logic        repair;
    logic [3:0]  relays;
    logic        alarm_nc;
    logic        irq;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        rd_log;
  } dfs_st_t;

  dfs_st_t     st_ff;
  dfs_st_t     nxt_st;
  logic [10:0] pins_sync;
  logic [7:0]  flt;
  logic [7:0]  sw_clr;
  logic [7:0]  new_bits;
  logic [7:0]  gone_bits;
  logic        acc_w;
  logic        acc_r;
  logic        log_we;
  logic [31:0] log_wdata;
  logic [31:0] log_rdata;

  dfs_sync #(.W(11)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({batt_low_pin, main_supply_pin, backup_supply_pin, fault_pin}),
    .dout    (pins_sync)
  );
  assign flt = pins_sync[7:0];

  dfs_log_mem u_log (
    .pclk  (pclk),
    .we    (log_we),
    .waddr (st_ff.wptr),
    .wdata (log_wdata),
    .raddr (st_ff.rptr),
    .rdata (log_rdata)
  );

  assign acc_w = psel && penable && pwrite && !st_ff.pready;
  assign acc_r = psel && penable && !pwrite && !st_ff.pready;

  always_comb begin
    nxt_st        = st_ff;
    sw_clr        = '0;
    log_we        = 1'b0;
    log_wdata     = '0;
    nxt_st.tstamp = st_ff.tstamp + 32'h1;
    // Software clear; time-code bit is never clearable
    if (acc_w && paddr == dfs_pkg::OFS_CLEAR) begin
      sw_clr = pwdata[7:0] & ~dfs_pkg::MASK_AUTO;
    end
    // Retained status restored once after reset
    if (!st_ff.loaded) begin
      nxt_st.loaded    = 1'b1;
      nxt_st.diag      = diag_retained | 8'(1 << dfs_pkg::DG_RESET);
      nxt_st.diag_prev = '0;
    end else begin
      nxt_st.diag[dfs_pkg::DG_TIMECODE] = flt[dfs_pkg::DG_TIMECODE];
      // Sticky faults: a new event wins over a clear
      nxt_st.diag = (nxt_st.diag & ~sw_clr & ~dfs_pkg::MASK_AUTO)
                  | (flt & ~dfs_pkg::MASK_AUTO)
                  | (nxt_st.diag & dfs_pkg::MASK_AUTO);
      nxt_st.diag_prev = st_ff.diag;
    end
    new_bits  = st_ff.diag & ~st_ff.diag_prev;
    gone_bits = st_ff.diag_prev & ~st_ff.diag;
    // One log entry per cycle: diagnostics, then config change
    if (st_ff.loaded && (new_bits != '0 || gone_bits != '0)) begin
      log_we    = 1'b1;
      log_wdata = {(new_bits != '0) ? dfs_pkg::EV_DIAG_SET : dfs_pkg::EV_DIAG_CLR,
                   (new_bits != '0) ? new_bits : gone_bits, st_ff.tstamp[15:0]};
    end else if (acc_w && paddr == dfs_pkg::OFS_CTRL && pwdata[dfs_pkg::CTRL_CFG_CHG]) begin
      log_we    = 1'b1;
      log_wdata = {dfs_pkg::EV_CFG_CHANGE, 8'h00, st_ff.tstamp[15:0]};
    end
    if (log_we) begin
      nxt_st.wptr = st_ff.wptr + 4'h1;
      if (st_ff.count != 5'(dfs_pkg::LOG_DEPTH)) begin
        nxt_st.count = st_ff.count + 5'h1;
      end else begin
        // Full: the oldest entry is overwritten, so the read side skips it
        nxt_st.rptr = st_ff.rptr + 4'h1;
      end
    end
    // Indicators
    nxt_st.led_bat  = pins_sync[10];
    nxt_st.led_main = pins_sync[9];
    nxt_st.led_bkp  = pins_sync[8];
    nxt_st.crit       = |(nxt_st.diag & dfs_pkg::MASK_CRITICAL);
    nxt_st.fault_flag = |(nxt_st.diag & ~dfs_pkg::MASK_CRITICAL);
    nxt_st.relays     = nxt_st.crit ? 4'h0 : relay_req;
    nxt_st.alarm_nc   = nxt_st.crit ? 1'b0
                      : (st_ff.ctrl[dfs_pkg::CTRL_ALARM_INV] ? !nxt_st.fault_flag : nxt_st.fault_flag);
    // Restart pulse on a newly raised recoverable fault other than the reset bit, only while not critical
    nxt_st.restart = 1'b0;
    if (|(new_bits & dfs_pkg::MASK_RECOVER & ~8'(1 << dfs_pkg::DG_RESET)) && !st_ff.crit) begin
      nxt_st.restart_cnt = dfs_pkg::RESTART_CYC8;
    end else if (st_ff.restart_cnt != 8'h00) begin
      nxt_st.restart_cnt = st_ff.restart_cnt - 8'h01;
    end
    nxt_st.restart = (nxt_st.restart_cnt != 8'h00);
    nxt_st.repair  = st_ff.restart && !nxt_st.restart;
    // Interrupt sources; set wins over clear
    if (acc_w && paddr == dfs_pkg::OFS_IRQ_CLR) begin
      nxt_st.irq_st = st_ff.irq_st & ~pwdata[3:0];
    end
    nxt_st.irq_st[dfs_pkg::IRQ_NEW_FAULT] |= (new_bits != '0);
    nxt_st.irq_st[dfs_pkg::IRQ_CRITICAL]  |= nxt_st.crit && !st_ff.crit;
    nxt_st.irq_st[dfs_pkg::IRQ_BATT_LOW]  |= pins_sync[10] && !st_ff.led_bat;
    nxt_st.irq_st[dfs_pkg::IRQ_LOG_DROP]  |= log_we && st_ff.count == 5'(dfs_pkg::LOG_DEPTH);
    if (acc_w && paddr == dfs_pkg::OFS_IRQ_EN) begin
      nxt_st.irq_en = pwdata[3:0];
    end
    if (acc_w && paddr == dfs_pkg::OFS_CTRL) begin
      nxt_st.ctrl[dfs_pkg::CTRL_ALARM_INV] = pwdata[dfs_pkg::CTRL_ALARM_INV];
    end
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_en);
    // APB: access phase waits one cycle on every other access and two when reading the log memory
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.rd_log  = 1'b0;
    if (acc_w) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !(paddr == dfs_pkg::OFS_CLEAR || paddr == dfs_pkg::OFS_IRQ_CLR
                         || paddr == dfs_pkg::OFS_IRQ_EN || paddr == dfs_pkg::OFS_CTRL);
    end else if (acc_r && paddr == dfs_pkg::OFS_LOG && !st_ff.rd_log) begin
      nxt_st.rd_log = 1'b1;
    end else if (acc_r) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = '0;
      case (paddr)
        dfs_pkg::OFS_DIAG:   nxt_st.prdata = {24'h0, st_ff.diag};
        dfs_pkg::OFS_IRQ_ST: nxt_st.prdata = {28'h0, st_ff.irq_st};
        dfs_pkg::OFS_IRQ_EN: nxt_st.prdata = {28'h0, st_ff.irq_en};
        dfs_pkg::OFS_STATUS: nxt_st.prdata = {21'h0, st_ff.count, st_ff.restart, st_ff.crit,
                                              st_ff.fault_flag, st_ff.led_bkp, st_ff.led_main, st_ff.led_bat};
        dfs_pkg::OFS_CTRL:   nxt_st.prdata = {30'h0, st_ff.ctrl};
        dfs_pkg::OFS_TIME:   nxt_st.prdata = st_ff.tstamp;
        dfs_pkg::OFS_LOG: begin
          if (st_ff.count != 5'h00) begin
            nxt_st.prdata = log_rdata;
            nxt_st.count  = nxt_st.count - 5'h1;
            nxt_st.rptr   = nxt_st.rptr + 4'h1;
          end
        end
        default:             nxt_st.pslverr = 1'b1;
      endcase
    end
    nxt_st.ctrl[dfs_pkg::CTRL_CFG_CHG] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata                       = st_ff.prdata;
  assign pready                       = st_ff.pready;
  assign pslverr                      = st_ff.pslverr;
  assign backup_battery_low_indicator = st_ff.led_bat;
  assign main_power_indicator         = st_ff.led_main;
  assign backup_power_indicator       = st_ff.led_bkp;
  assign device_fault_flag            = st_ff.fault_flag;
  assign critical_error               = st_ff.crit;
  assign device_restart               = st_ff.restart;
  assign config_repair                = st_ff.repair;
  assign relay_out                    = st_ff.relays;
  assign alarm_relay_nc_closed        = st_ff.alarm_nc;
  assign diag_store                   = st_ff.diag;
  assign irq                          = st_ff.irq;

  property p_crit_release;
    @(posedge pclk) disable iff (!presetn) st_ff.crit |-> relay_out == 4'h0 && !alarm_relay_nc_closed;
  endproperty
  a_crit_release: assert property (p_crit_release) else $error("relays not released");

  property p_crit_class;
    @(posedge pclk) disable iff (!presetn) $past(st_ff.loaded) && |($past(flt) & 8'h78) |-> critical_error;
  endproperty
  a_crit_class: assert property (p_crit_class) else $error("critical class wrong");

  property p_flag;
    @(posedge pclk) disable iff (!presetn) device_fault_flag == |(diag_store & 8'h87);
  endproperty
  a_flag: assert property (p_flag) else $error("fault flag mismatch");

  property p_flag_drop;
    @(posedge pclk) disable iff (!presetn) $fell(|(diag_store & 8'h87)) |-> !device_fault_flag;
  endproperty
  a_flag_drop: assert property (p_flag_drop) else $error("fault flag late");

  property p_tc_auto;
    @(posedge pclk) disable iff (!presetn) st_ff.loaded && $past(st_ff.loaded) |->
      diag_store[0] == $past(flt[0]);
  endproperty
  a_tc_auto: assert property (p_tc_auto) else $error("time-code bit not following cause");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn) st_ff.loaded && $past(diag_store[1]) && !$past(sw_clr[1]) |-> diag_store[1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("recoverable fault lost");

  property p_restart;
    @(posedge pclk) disable iff (!presetn) $rose(device_restart) |-> device_restart [*8] ##[1:20] config_repair;
  endproperty
  a_restart: assert property (p_restart) else $error("restart or repair missing");

  property p_log;
    @(posedge pclk) disable iff (!presetn) st_ff.loaded && $changed(diag_store) |-> log_we;
  endproperty
  a_log: assert property (p_log) else $error("diagnostic not logged");

  property p_led;
    @(posedge pclk) disable iff (!presetn) backup_battery_low_indicator == $past(pins_sync[10]);
  endproperty
  a_led: assert property (p_led) else $error("battery led wrong");

  c_crit:    cover property (@(posedge pclk) disable iff (!presetn) $rose(critical_error));
  c_restart: cover property (@(posedge pclk) disable iff (!presetn) $rose(config_repair));
  c_clear:   cover property (@(posedge pclk) disable iff (!presetn) $fell(device_fault_flag));
endmodule

//--- sim/dfs_diag_top_bench.sv
// Self-checking bench for the diagnostics block over APB and its pins
module dfs_diag_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        batt_low_pin;
  logic        main_supply_pin;
  logic        backup_supply_pin;
  logic [7:0]  fault_pin;
  logic [3:0]  relay_req;
  logic [7:0]  diag_retained;
  logic        bat_ind;
  logic        main_ind;
  logic        bkp_ind;
  logic        flag;
  logic        crit;
  logic        restart;
  logic        repair;
  logic [3:0]  relay_out;
  logic        alarm_nc;
  logic [7:0]  diag_store;
  logic        irq;
  int          err_count;
  int          tests_run;
  int          seed;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  ret;
  logic [2:0]  pins;
  int          n;
  int          m;

  dfs_diag_top dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .batt_low_pin(batt_low_pin), .main_supply_pin(main_supply_pin),
    .backup_supply_pin(backup_supply_pin), .fault_pin(fault_pin), .relay_req(relay_req),
    .diag_retained(diag_retained), .backup_battery_low_indicator(bat_ind),
    .main_power_indicator(main_ind), .backup_power_indicator(bkp_ind), .device_fault_flag(flag),
    .critical_error(crit), .device_restart(restart), .config_repair(repair),
    .relay_out(relay_out), .alarm_relay_nc_closed(alarm_nc), .diag_store(diag_store), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [3:0] exp_relay(input logic [3:0] req, input logic c);
    exp_relay = c ? 4'h0 : req;
  endfunction

  task automatic final_report();
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (10) @(posedge pclk);
  endtask

  initial begin
    #200000;
    err_count++;
    final_report();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    seed = 32'h946B0A54;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    batt_low_pin = 1'b0;
    main_supply_pin = 1'b0;
    backup_supply_pin = 1'b0;
    fault_pin = 8'h00;
    relay_req = 4'h0;
    ret = 8'($random(seed)) & 8'h06;
    diag_retained = ret;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Retained image plus reset marker after power-up
    apb(1'b0, dfs_pkg::OFS_DIAG, 32'h0);
    chk(rd, {24'h0, ret | 8'h80});
    settle();
    chk(flag, 1'b1);
    chk(diag_store, ret | 8'h80);
    apb(1'b1, dfs_pkg::OFS_CLEAR, 32'hFE);
    apb(1'b0, dfs_pkg::OFS_DIAG, 32'h0);
    chk(rd, 32'h0);
    @(posedge pclk);
    chk(flag, 1'b0);
    apb(1'b1, dfs_pkg::OFS_IRQ_CLR, 32'hF);
    apb(1'b1, dfs_pkg::OFS_IRQ_EN, 32'h1);
    apb(1'b1, dfs_pkg::OFS_CTRL, 32'h1);
    settle();
    chk(alarm_nc, 1'b1);
    chk(irq, 1'b0);
    // Time-code fault follows its cause and refuses software clear
    fault_pin <= 8'h01;
    settle();
    chk(flag, 1'b1);
    chk(alarm_nc, 1'b0);
    chk(restart, 1'b0);
    chk(irq, 1'b1);
    apb(1'b1, dfs_pkg::OFS_CLEAR, 32'h1);
    apb(1'b0, dfs_pkg::OFS_DIAG, 32'h0);
    chk(rd, 32'h1);
    fault_pin <= 8'h00;
    settle();
    apb(1'b0, dfs_pkg::OFS_DIAG, 32'h0);
    chk(rd, 32'h0);
    chk(flag, 1'b0);
    apb(1'b0, dfs_pkg::OFS_IRQ_ST, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, dfs_pkg::OFS_IRQ_CLR, 32'hF);
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, dfs_pkg::OFS_IRQ_EN, 32'h0);
    // Recoverable fault restarts, repairs and sticks until cleared
    fault_pin <= 8'h02;
    n = 0;
    m = 0;
    repeat (60) begin
      @(posedge pclk);
      if (restart === 1'b1) n++;
      if (repair === 1'b1) m++;
    end
    chk(n, dfs_pkg::RESTART_CYC);
    chk(m, 1);
    fault_pin <= 8'h00;
    settle();
    apb(1'b0, dfs_pkg::OFS_DIAG, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, dfs_pkg::OFS_CLEAR, 32'h2);
    apb(1'b0, dfs_pkg::OFS_DIAG, 32'h0);
    chk(rd, 32'h0);
    @(posedge pclk);
    chk(flag, 1'b0);
    // Drain the log, then check self-supervision entries
    n = 0;
    do begin
      apb(1'b0, dfs_pkg::OFS_LOG, 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 40);
    apb(1'b1, dfs_pkg::OFS_CTRL, 32'h3);
    apb(1'b0, dfs_pkg::OFS_LOG, 32'h0);
    chk(rd[31:24], dfs_pkg::EV_CFG_CHANGE);
    fault_pin <= 8'h04;
    settle();
    apb(1'b0, dfs_pkg::OFS_LOG, 32'h0);
    chk(rd[31:24], dfs_pkg::EV_DIAG_SET);
    fault_pin <= 8'h00;
    settle();
    apb(1'b1, dfs_pkg::OFS_CLEAR, 32'h4);
    settle();
    chk(flag, 1'b0);
    // Each critical cause releases relays until cleared
    for (int b = 3; b <= 6; b++) begin
      relay_req <= 4'($random(seed)) | 4'h1;
      settle();
      chk(relay_out, exp_relay(relay_req, 1'b0));
      fault_pin <= 8'h01 << b;
      settle();
      chk(crit, 1'b1);
      chk(relay_out, exp_relay(relay_req, 1'b1));
      chk(alarm_nc, 1'b0);
      fault_pin <= 8'h00;
      settle();
      chk(crit, 1'b1);
      apb(1'b1, dfs_pkg::OFS_CLEAR, 32'h1 << b);
      settle();
      chk(crit, 1'b0);
      chk(relay_out, exp_relay(relay_req, 1'b0));
    end
    // Indicators follow their own pins
    for (int i = 0; i < 8; i++) begin
      pins = (i < 4) ? 3'(i * 5) : 3'($random(seed));
      batt_low_pin <= pins[0];
      main_supply_pin <= pins[1];
      backup_supply_pin <= pins[2];
      settle();
      chk(bat_ind, pins[0]);
      chk({bkp_ind, main_ind}, pins[2:1]);
      apb(1'b0, dfs_pkg::OFS_STATUS, 32'h0);
      chk(rd[2:0], pins);
    end
    // Log overflow keeps the newest entries and raises its interrupt bit
    repeat (17) apb(1'b1, dfs_pkg::OFS_CTRL, 32'h3);
    apb(1'b0, dfs_pkg::OFS_IRQ_ST, 32'h0);
    chk(rd[dfs_pkg::IRQ_LOG_DROP], 1'b1);
    apb(1'b0, dfs_pkg::OFS_STATUS, 32'h0);
    chk(rd[10:6], dfs_pkg::LOG_DEPTH);
    apb(1'b0, dfs_pkg::OFS_LOG, 32'h0);
    chk(rd[31:24], dfs_pkg::EV_CFG_CHANGE);
    // Unmapped and read-only accesses are refused
    apb(1'b0, 8'hFC, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, dfs_pkg::OFS_DIAG, 32'h5A);
    chk(er, 1'b1);
    final_report();
  end
endmodule
